// [caf_regs.svh]
// Register map, field positions and reset values of the acceptance filter block
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH

// Word indexes (byte address = index * 4)
`define CAF_IDX_FSTD 6'h00
`define CAF_IDX_FEXT 6'h10
`define CAF_IDX_MSTD 6'h20
`define CAF_IDX_MEXT 6'h24
`define CAF_IDX_SEL_LO 6'h28
`define CAF_IDX_SEL_HI 6'h29
`define CAF_IDX_ENABLE 6'h2A
`define CAF_IDX_BUFPTR 6'h2C
`define CAF_IDX_LAST 6'h30

// Field positions
`define CAF_SID_MSB 15
`define CAF_SID_LSB 5
`define CAF_TYPE_BIT 3
`define CAF_EIDH_MSB 1
`define CAF_EIDH_LSB 0
`define CAF_LAST_HIT_BIT 8

// Implemented bits and reset values
`define CAF_STD_IMPL 16'hFFEB
`define CAF_SEL_RESET 16'h0000
`define CAF_ENABLE_RESET 16'hFFFF
`define CAF_PTR_RESET 16'h0000
`define CAF_ID_RESET 16'h0000
`define CAF_PTR_FIFO 4'hF

`endif

// [caf_pkg.sv]
// Types shared by the acceptance filter block
`default_nettype none
package caf_pkg;
	typedef logic [15:0] caf_word_type;
	typedef logic [3:0] caf_index_type;
	typedef enum logic [1:0] {
		CAF_MSK0 = 2'b00,
		CAF_MSK1 = 2'b01,
		CAF_MSK2 = 2'b10,
		CAF_MSK_RSVD = 2'b11
	} caf_mask_src_type;
	typedef enum logic {
		CAF_BUS_IDLE = 1'b0,
		CAF_BUS_ANSWER = 1'b1
	} caf_bus_state_type;
endpackage : caf_pkg
`default_nettype wire

// [caf_filter_match.sv]
// One acceptance filter compared against a received identifier
`timescale 1ns/10ps
`default_nettype none
`include "caf_regs.svh"
module caf_filter_match (
	// Filter and selected mask
	input wire caf_pkg::caf_word_type filt_std,
	input wire caf_pkg::caf_word_type filt_ext,
	input wire caf_pkg::caf_word_type mask_std,
	input wire caf_pkg::caf_word_type mask_ext,
	input wire logic filt_enable,
	input wire logic mask_ok,
	// Received identifier
	input wire logic [10:0] rx_std_id,
	input wire logic [17:0] rx_ext_id,
	input wire logic rx_id_is_ext,
	// Result
	output logic hit
);
	import caf_pkg::*;
	logic [10:0] std_diff;
	logic [17:0] ext_diff;
	logic type_ok;

	assign std_diff = (filt_std[`CAF_SID_MSB:`CAF_SID_LSB] ^ rx_std_id)
		& mask_std[`CAF_SID_MSB:`CAF_SID_LSB];
	assign ext_diff = ({filt_std[`CAF_EIDH_MSB:`CAF_EIDH_LSB], filt_ext} ^ rx_ext_id)
		& {mask_std[`CAF_EIDH_MSB:`CAF_EIDH_LSB], mask_ext};
	// Format must agree only when the mask asks for it
	assign type_ok = !mask_std[`CAF_TYPE_BIT]
		|| (filt_std[`CAF_TYPE_BIT] == rx_id_is_ext);
	// Standard frames compare the standard part alone
	assign hit = filt_enable && mask_ok && type_ok && (std_diff == 11'h000)
		&& (!rx_id_is_ext || (ext_diff == 18'h0_0000));
endmodule : caf_filter_match
`default_nettype wire

// [caf_top.sv]
// Acceptance filter bank with Avalon-MM register access
`timescale 1ns/10ps
`default_nettype none
`include "caf_regs.svh"
module caf_top #(
	parameter int NUM_FILTERS = 16,
	parameter int NUM_MASKS = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Identifier from the receive engine
	input wire logic rx_id_valid,
	input wire logic [10:0] rx_std_id,
	input wire logic [17:0] rx_ext_id,
	input wire logic rx_id_is_ext,
	// Acceptance result
	output logic match_valid,
	output logic match_hit,
	output caf_pkg::caf_index_type match_filter,
	output caf_pkg::caf_index_type match_buffer_ptr
);
	import caf_pkg::*;

	if (NUM_FILTERS != 16 || NUM_MASKS != 3) begin : g_bad_size
		$error("caf_top: register layout serves 16 filters and 3 masks only");
	end

	caf_word_type filt_std_reg [NUM_FILTERS];
	caf_word_type filt_ext_reg [NUM_FILTERS];
	caf_word_type mask_std_reg [NUM_MASKS];
	caf_word_type mask_ext_reg [NUM_MASKS];
	caf_word_type sel_lo_reg;
	caf_word_type sel_hi_reg;
	caf_word_type enable_reg;
	caf_word_type bufptr_reg [4];
	caf_word_type last_reg;
	caf_bus_state_type bus_state_reg;
	logic [31:0] rdata_next;
	logic [5:0] idx;
	logic aligned;
	logic wr_take;
	caf_word_type wmask;
	caf_word_type wval;
	logic [31:0] sel_all;
	logic [NUM_FILTERS-1:0] hit_vec;
	caf_index_type win_idx;
	logic win_any;
	caf_index_type win_ptr;

	assign idx = avs_address[7:2];
	assign aligned = (avs_address[1:0] == 2'b00);
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign sel_all = {sel_hi_reg, sel_lo_reg};
	// A write lands only at the edge where waitrequest is seen low
	assign wr_take = avs_write && (bus_state_reg == CAF_BUS_ANSWER) && aligned;

	function automatic caf_word_type merge(input caf_word_type old, input caf_word_type m,
		input caf_word_type v);
		merge = (old & ~m) | (v & m);
	endfunction : merge

	assign wval = avs_writedata[15:0];

	// Bus handshake: one wait cycle, then one answer cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_state_reg <= CAF_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			unique case (bus_state_reg)
				CAF_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state_reg <= CAF_BUS_ANSWER;
						avs_waitrequest <= 1'b0;
					end
				end
				CAF_BUS_ANSWER: begin
					bus_state_reg <= CAF_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read data is sampled when the answer starts
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (aligned) begin
			if (idx < `CAF_IDX_FSTD + 6'(NUM_FILTERS)) begin
				rdata_next[15:0] = filt_std_reg[idx[3:0]] & `CAF_STD_IMPL;
			end else if (idx >= `CAF_IDX_FEXT && idx < `CAF_IDX_FEXT + 6'(NUM_FILTERS)) begin
				rdata_next[15:0] = filt_ext_reg[idx[3:0]];
			end else if (idx >= `CAF_IDX_MSTD && idx < `CAF_IDX_MSTD + 6'(NUM_MASKS)) begin
				rdata_next[15:0] = mask_std_reg[idx[1:0]] & `CAF_STD_IMPL;
			end else if (idx >= `CAF_IDX_MEXT && idx < `CAF_IDX_MEXT + 6'(NUM_MASKS)) begin
				rdata_next[15:0] = mask_ext_reg[idx[1:0]];
			end else if (idx == `CAF_IDX_SEL_LO) begin
				rdata_next[15:0] = sel_lo_reg;
			end else if (idx == `CAF_IDX_SEL_HI) begin
				rdata_next[15:0] = sel_hi_reg;
			end else if (idx == `CAF_IDX_ENABLE) begin
				rdata_next[15:0] = enable_reg;
			end else if (idx >= `CAF_IDX_BUFPTR && idx < `CAF_IDX_BUFPTR + 6'(NUM_FILTERS / 4)) begin
				rdata_next[15:0] = bufptr_reg[idx[1:0]];
			end else if (idx == `CAF_IDX_LAST) begin
				rdata_next[15:0] = last_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_state_reg == CAF_BUS_IDLE && avs_read) begin
			avs_readdata <= rdata_next;
		end
	end

	// Filter identifier registers, a standard and an extended one per filter
	for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filt_regs
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				filt_std_reg[i] <= `CAF_ID_RESET;
				filt_ext_reg[i] <= `CAF_ID_RESET;
			end else if (wr_take && idx == `CAF_IDX_FSTD + 6'(i)) begin
				filt_std_reg[i] <= merge(filt_std_reg[i], wmask & `CAF_STD_IMPL, wval);
			end else if (wr_take && idx == `CAF_IDX_FEXT + 6'(i)) begin
				filt_ext_reg[i] <= merge(filt_ext_reg[i], wmask, wval);
			end
		end
	end

	// Mask registers
	for (genvar m = 0; m < NUM_MASKS; m++) begin : g_mask_regs
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				mask_std_reg[m] <= `CAF_ID_RESET;
				mask_ext_reg[m] <= `CAF_ID_RESET;
			end else if (wr_take && idx == `CAF_IDX_MSTD + 6'(m)) begin
				mask_std_reg[m] <= merge(mask_std_reg[m], wmask & `CAF_STD_IMPL, wval);
			end else if (wr_take && idx == `CAF_IDX_MEXT + 6'(m)) begin
				mask_ext_reg[m] <= merge(mask_ext_reg[m], wmask, wval);
			end
		end
	end

	// Mask selectors
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sel_lo_reg <= `CAF_SEL_RESET;
			sel_hi_reg <= `CAF_SEL_RESET;
		end else if (wr_take && idx == `CAF_IDX_SEL_LO) begin
			sel_lo_reg <= merge(sel_lo_reg, wmask, wval);
		end else if (wr_take && idx == `CAF_IDX_SEL_HI) begin
			sel_hi_reg <= merge(sel_hi_reg, wmask, wval);
		end
	end

	// Filter enables
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_reg <= `CAF_ENABLE_RESET;
		end else if (wr_take && idx == `CAF_IDX_ENABLE) begin
			enable_reg <= merge(enable_reg, wmask, wval);
		end
	end

	// Buffer pointers, four filters per register
	for (genvar p = 0; p < 4; p++) begin : g_ptr_regs
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				bufptr_reg[p] <= `CAF_PTR_RESET;
			end else if (wr_take && idx == `CAF_IDX_BUFPTR + 6'(p)) begin
				bufptr_reg[p] <= merge(bufptr_reg[p], wmask, wval);
			end
		end
	end

	// Per-filter comparison against its selected mask
	for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_match
		caf_mask_src_type src;
		caf_word_type sel_std;
		caf_word_type sel_ext;
		logic src_ok;
		assign src = caf_mask_src_type'(sel_all[2*i +: 2]);
		assign src_ok = (src != CAF_MSK_RSVD);
		assign sel_std = src_ok ? mask_std_reg[src] : `CAF_ID_RESET;
		assign sel_ext = src_ok ? mask_ext_reg[src] : `CAF_ID_RESET;
		caf_filter_match u_match (
			.filt_std(filt_std_reg[i]),
			.filt_ext(filt_ext_reg[i]),
			.mask_std(sel_std),
			.mask_ext(sel_ext),
			.filt_enable(enable_reg[i]),
			.mask_ok(src_ok),
			.rx_std_id(rx_std_id),
			.rx_ext_id(rx_ext_id),
			.rx_id_is_ext(rx_id_is_ext),
			.hit(hit_vec[i])
		);
	end

	// Lowest numbered hitting filter wins
	always_comb begin
		win_idx = 4'h0;
		win_any = 1'b0;
		for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				win_idx = 4'(i);
				win_any = 1'b1;
			end
		end
		win_ptr = bufptr_reg[win_idx[3:2]][4*win_idx[1:0] +: 4];
	end

	// Result of each identifier, one cycle after it is presented
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			match_valid <= 1'b0;
			match_hit <= 1'b0;
			match_filter <= 4'h0;
			match_buffer_ptr <= 4'h0;
		end else begin
			match_valid <= rx_id_valid;
			if (rx_id_valid) begin
				match_hit <= win_any;
				match_filter <= win_idx;
				match_buffer_ptr <= win_any ? win_ptr : 4'h0;
			end
		end
	end

	// Last result, visible to software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			last_reg <= 16'h0000;
		end else if (rx_id_valid) begin
			last_reg <= {7'h00, win_any, win_idx, (win_any ? win_ptr : 4'h0)};
		end
	end

	// Checks
	logic [NUM_FILTERS-1:0] rsvd_bits;
	logic [NUM_MASKS-1:0] rsvd_mask_bits;
	for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_rsvd
		assign rsvd_bits[i] = |(filt_std_reg[i] & ~`CAF_STD_IMPL);
	end
	for (genvar m = 0; m < NUM_MASKS; m++) begin : g_rsvd_mask
		assign rsvd_mask_bits[m] = |(mask_std_reg[m] & ~`CAF_STD_IMPL);
	end
	caf_mask_src_type f0_src;
	logic f0_mask_type_match_enable;
	logic [10:0] f0_sdiff;
	assign f0_src = caf_mask_src_type'(sel_lo_reg[1:0]);
	assign f0_mask_type_match_enable = (f0_src != CAF_MSK_RSVD) && mask_std_reg[f0_src][`CAF_TYPE_BIT];
	assign f0_sdiff = (f0_src == CAF_MSK_RSVD) ? 11'h000
		: (filt_std_reg[0][`CAF_SID_MSB:`CAF_SID_LSB] ^ rx_std_id)
		& mask_std_reg[f0_src][`CAF_SID_MSB:`CAF_SID_LSB];

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_pending;
		(avs_read || avs_write) && avs_waitrequest && bus_state_reg == CAF_BUS_IDLE;
	endsequence
	sequence s_answer;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	chk_bus_answer: assert property (s_pending |=> s_answer)
		else $error("request not answered in one cycle");
	chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_sel_reset: assert property ($fell(sys_rst) |-> sel_all == 32'h0000_0000)
		else $error("mask selectors not zero after reset");
	chk_rsvd_zero: assert property (rsvd_bits == '0)
		else $error("unimplemented filter bits not zero");
	chk_match_pulse: assert property (rx_id_valid |=> match_valid ##1 !match_valid || $past(rx_id_valid))
		else $error("match result timing wrong");
	chk_disabled_no: assert property (rx_id_valid && !enable_reg[0] |-> !hit_vec[0])
		else $error("disabled filter produced a hit");
	chk_type_gate: assert property (f0_mask_type_match_enable && filt_std_reg[0][`CAF_TYPE_BIT] != rx_id_is_ext
		|-> !hit_vec[0])
		else $error("frame type mismatch produced a hit");
	chk_sid_gate: assert property (f0_sdiff != 11'h000 |-> !hit_vec[0])
		else $error("masked standard bit mismatch produced a hit");
	chk_hit_route: assert property (rx_id_valid && win_any
		|=> match_hit && match_buffer_ptr == $past(win_ptr))
		else $error("hit routed to wrong buffer");
	chk_no_hit: assert property (rx_id_valid && hit_vec == '0 |=> !match_hit)
		else $error("hit reported with no filter matching");
	chk_rsvd_mask: assert property (rsvd_mask_bits == '0)
		else $error("unimplemented mask bits not zero");
	chk_rsvd_src: assert property (f0_src == CAF_MSK_RSVD |-> !hit_vec[0])
		else $error("filter with reserved mask source produced a hit");
endmodule : caf_top
`default_nettype wire

// [caf_rx_engine.sv]
// Receive engine model that presents identifiers to the filter bank
`timescale 1ns/10ps
`default_nettype none
module caf_rx_engine (
	// Clock
	input wire logic clk,
	// Identifier to the filter bank
	output logic rx_id_valid,
	output logic [10:0] rx_std_id,
	output logic [17:0] rx_ext_id,
	output logic rx_id_is_ext
);
	initial begin
		rx_id_valid = 1'b0;
		rx_std_id = 11'h000;
		rx_ext_id = 18'h0_0000;
		rx_id_is_ext = 1'b0;
	end
	// Back-to-back calls give identifiers on consecutive cycles
	task automatic send(input logic [10:0] s, input logic [17:0] e, input logic x);
		@(posedge clk);
		rx_id_valid <= 1'b1;
		rx_std_id <= s;
		rx_ext_id <= e;
		rx_id_is_ext <= x;
	endtask : send
	// Unqualified lines show the inverse of the last value
	task automatic idle();
		@(posedge clk);
		rx_id_valid <= 1'b0;
		rx_std_id <= ~rx_std_id;
		rx_ext_id <= ~rx_ext_id;
		rx_id_is_ext <= ~rx_id_is_ext;
	endtask : idle
endmodule : caf_rx_engine
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the acceptance filter bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import caf_pkg::*;
	logic clk, sys_rst, avs_read, avs_write, avs_waitrequest, match_valid, match_hit;
	logic [7:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	wire logic rx_id_valid, rx_id_is_ext;
	wire logic [10:0] rx_std_id;
	wire logic [17:0] rx_ext_id;
	caf_index_type match_filter, match_buffer_ptr;
	int errors, comparisons, cycles;
	logic [15:0] regs [0:63];
	logic [8:0] exp_q [$];
	logic [8:0] last_exp;
	caf_top caf_top_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_id_valid(rx_id_valid), .rx_std_id(rx_std_id),
		.rx_ext_id(rx_ext_id), .rx_id_is_ext(rx_id_is_ext), .match_valid(match_valid),
		.match_hit(match_hit), .match_filter(match_filter), .match_buffer_ptr(match_buffer_ptr));
	caf_rx_engine caf_rx_engine_i (.clk(clk), .rx_id_valid(rx_id_valid), .rx_std_id(rx_std_id),
		.rx_ext_id(rx_ext_id), .rx_id_is_ext(rx_id_is_ext));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask : check
	task automatic give_verdict();
		$display("counts: errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	function automatic logic mapped(input logic [5:0] i);
		return i <= 6'h22 || i inside {[6'h24:6'h26], [6'h28:6'h2A], [6'h2C:6'h2F]};
	endfunction : mapped
	// Lowest-numbered accepting filter wins
	function automatic logic [8:0] model(input logic [10:0] s, input logic [17:0] e, input logic x);
		logic [15:0] f, ms, me;
		logic [1:0] sl;
		logic ok;
		for (int i = 0; i < 16; i++) begin
			sl = regs[6'h28 + i / 8][2 * (i % 8) +: 2];
			f = regs[i];
			ms = regs[6'h20 + sl];
			me = regs[6'h24 + sl];
			ok = sl != 2'b11 && regs[6'h2A][i] && ((s ^ f[15:5]) & ms[15:5]) == 0;
			if (x) ok = ok && ((e[17:16] ^ f[1:0]) & ms[1:0]) == 0 && ((e[15:0] ^ regs[16 + i]) & me) == 0;
			if (ms[3]) ok = ok && f[3] == x;
			if (ok) return {1'b1, 4'(i), regs[6'h2C + i / 4][4 * (i % 4) +: 4]};
		end
		return 9'h000;
	endfunction : model
	task automatic bus(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [15:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_byteenable <= be;
		avs_writedata <= {16'($urandom), d};
		// Only the cycle ceiling ends a wait that never gets an answer
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [15:0] d);
		logic [31:0] q;
		logic [15:0] bm;
		bm = {{8{be[1]}}, {8{be[0]}}};
		if (a[7:2] < 6'h10 || a[7:2] inside {[6'h20:6'h22]}) bm = bm & 16'hFFEB;
		bus(1'b1, a, be, d, q);
		if (mapped(a[7:2]) && a[1:0] == 2'b00) regs[a[7:2]] = (regs[a[7:2]] & ~bm) | (d & bm);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic [31:0] q, e;
		bus(1'b0, a, 4'hF, 16'($urandom), q);
		e = 32'h0000_0000;
		if (a[1:0] == 2'b00 && a[7:2] == 6'h30) e = {23'h00_0000, last_exp};
		else if (a[1:0] == 2'b00 && mapped(a[7:2])) e = {16'h0000, regs[a[7:2]]};
		check("readdata", e, q);
	endtask : rd
	task automatic rst();
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (regs[i]) regs[i] = 16'h0000;
		regs[6'h2A] = 16'hFFFF;
		last_exp = 9'h000;
		exp_q.delete();
		for (int a = 0; a < 8'hD0; a += 4) rd(8'(a));
		$display("test reset_values done");
	endtask : rst
	task automatic send_id();
		int t;
		logic [10:0] s;
		logic [17:0] e;
		logic x;
		t = $urandom % 16;
		s = regs[t][15:5] ^ (($urandom % 2) ? 11'(1 << ($urandom % 11)) : 11'h000);
		e = {regs[t][1:0], regs[16 + t]} ^ (($urandom % 2) ? 18'(1 << ($urandom % 18)) : 18'h0_0000);
		x = 1'($urandom % 2);
		last_exp = model(s, e, x);
		exp_q.push_back(last_exp);
		caf_rx_engine_i.send(s, e, x);
	endtask : send_id
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			$display("timeout");
			give_verdict();
		end
	end
	always @(posedge clk) begin : monitor
		logic [8:0] e;
		if (match_valid === 1'b1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
			check("match_hit", 32'(e[8]), 32'(match_hit));
			check("match_filter", 32'(e[7:4]), 32'(match_filter));
			check("match_buffer_ptr", 32'(e[3:0]), 32'(match_buffer_ptr));
		end
	end
	initial begin
		{sys_rst, avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
		{errors, comparisons, cycles} = '0;
		void'($urandom(11938));
		rst();
		wr(8'h3C, 4'h3, 16'hFFFF);
		rd(8'h3C);
		wr(8'h88, 4'h3, 16'hFFFF);
		rd(8'h88);
		$display("test unimplemented_bits done");
		// Everything used is programmed before identifiers arrive
		for (int r = 0; r < 24; r++) begin
			for (int i = 0; i < 16; i++) begin
				wr(8'(4 * i), 4'h3, 16'($urandom));
				wr(8'(8'h40 + 4 * i), 4'h3, 16'($urandom));
			end
			for (int m = 0; m < 3; m++) begin
				wr(8'(8'h80 + 4 * m), 4'h3, 16'($urandom & $urandom));
				wr(8'(8'h90 + 4 * m), 4'h3, 16'($urandom & $urandom));
			end
			wr(8'hA0, 4'(1 + $urandom % 3), 16'($urandom));
			wr(8'hA4, 4'(1 + $urandom % 3), 16'($urandom));
			wr(8'hA8, 4'h3, 16'($urandom | $urandom));
			for (int k = 0; k < 4; k++) wr(8'(8'hB0 + 4 * k), 4'h3, 16'($urandom));
			wr(8'($urandom), 4'h3, 16'($urandom));
			for (int k = 0; k < 8; k++) send_id();
			caf_rx_engine_i.idle();
			repeat (2) @(posedge clk);
			rd(8'hC0);
			repeat (4) rd(8'($urandom));
		end
		$display("test random_filtering done");
		check("pending results", 32'h0000_0000, 32'(exp_q.size()));
		rst();
		// Result path after a mid-run reset, with every register at its reset value
		send_id();
		caf_rx_engine_i.idle();
		repeat (2) @(posedge clk);
		rd(8'hC0);
		check("pending after reset", 32'h0000_0000, 32'(exp_q.size()));
		$display("test filtering_after_reset done");
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
